// >>> logic/ssx_defines.svh
`ifndef SSX_DEFINES_SVH
`define SSX_DEFINES_SVH

// shift register length and parallel output width
`define SSX_STAGES 8
// event buffer depth, must be a power of two
`define SSX_FIFO_DEPTH 8
// event word: {kind, data bit, strobe level}
`define SSX_EVT_WIDTH 3
`define SSX_EVT_STROBE_BIT 0
`define SSX_EVT_DATA_BIT 1
`define SSX_EVT_KIND_BIT 2
// reset values
`define SSX_SHIFT_RESET 8'h00
`define SSX_LATCH_RESET 8'h00
`define SSX_STROBE_RESET 1'h1

`endif

// >>> logic/ssx_pkg.sv
package ssx_pkg;

    typedef enum logic {
        SSX_EVT_STROBE = 1'b0,
        SSX_EVT_SHIFT = 1'b1
    } ssx_evt_kind_t;

    typedef logic [7:0] ssx_word_t;

endpackage : ssx_pkg

// >>> logic/ssx_edge.sv
`timescale 1ns/1ps
// rising-edge and change detection on pin levels
module ssx_edge #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin levels
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] level_init,
    // detected events
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] change
);

    logic [WIDTH-1:0] prev_reg;
    logic primed_reg;

    // reset value is a constant; the first sample after release primes the history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            primed_reg <= 1'b0;
        end else begin
            primed_reg <= 1'b1;
        end
    end

    // before priming, compare against the assumed idle levels
    always_comb begin
        rise = level & ~(primed_reg ? prev_reg : level_init);
        change = level ^ (primed_reg ? prev_reg : level_init);
    end

endmodule : ssx_edge

// >>> logic/ssx_fifo.sv
`timescale 1ns/1ps
module ssx_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

endmodule : ssx_fifo

// >>> logic/ssx_expander.sv
// Function
// - eight-stage shift register whose contents end up on eight parallel outputs.
// - each shift clock rising edge shifts the data input into stage one, except an edge that arrives while the event buffer is full.
// - strobe high and clear inactive: shifting leaves the output latch unchanged.
// - strobe going low copies the shift register into the latch.
// - strobe held low: latch follows the shift register on every shift.
// - latch contents drive the eight parallel outputs at all times.
// - clear low zeroes every latch bit regardless of clock and strobe.
// - clear never touches the shift register.
// - cascade output shows shift data independent of clear and strobe.
`timescale 1ns/1ps
`include "ssx_defines.svh"
module ssx_expander
    import ssx_pkg::*;
#(
    parameter int STAGES = `SSX_STAGES,
    parameter int FIFO_DEPTH = `SSX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host serial pins
    input wire logic serial_data,
    input wire logic shift_clk,
    input wire logic latch_load,
    input wire logic latch_clear_n,
    // event flow
    output logic event_ready,
    output logic event_dropped,
    input wire logic apply_stall,
    // device pins
    output logic [STAGES-1:0] parallel_out,
    output logic serial_out
);

    localparam int EW = `SSX_EVT_WIDTH;

    // field helpers shared by the fill and drain sides, so packing and unpacking cannot drift apart
    function automatic logic [EW-1:0] evt_pack(input logic is_shift, input logic data, input logic strobe);
        logic [EW-1:0] word;
        word = '0;
        word[`SSX_EVT_KIND_BIT] = is_shift;
        word[`SSX_EVT_DATA_BIT] = data;
        word[`SSX_EVT_STROBE_BIT] = strobe;
        return word;
    endfunction : evt_pack

    function automatic logic evt_is_shift(input logic [EW-1:0] word);
        return word[`SSX_EVT_KIND_BIT] == SSX_EVT_SHIFT;
    endfunction : evt_is_shift

    function automatic logic evt_data(input logic [EW-1:0] word);
        return word[`SSX_EVT_DATA_BIT];
    endfunction : evt_data

    function automatic logic evt_strobe(input logic [EW-1:0] word);
        return word[`SSX_EVT_STROBE_BIT];
    endfunction : evt_strobe

    logic [1:0] rise;
    logic [1:0] change;
    logic shift_event;
    logic strobe_event;
    logic evt_valid;
    logic [EW-1:0] evt_word;
    logic q_valid;
    logic q_ready;
    logic [EW-1:0] q_word;
    logic apply;
    logic apply_shift;
    logic [STAGES-1:0] shift_reg;
    logic [STAGES-1:0] shift_next;
    logic [STAGES-1:0] shift_in;
    logic [STAGES-1:0] latch_reg;
    logic strobe_reg;
    logic strobe_next;
    logic dropped_reg;

    // bit 0 shift clock, bit 1 strobe; both idle high
    ssx_edge #(
        .WIDTH(2)
    ) u_edge (
        .clk(clk),
        .rst(rst),
        .level({latch_load, shift_clk}),
        .level_init(2'h3),
        .rise(rise),
        .change(change)
    );

    assign shift_event = rise[0];
    assign strobe_event = change[1];
    assign evt_valid = shift_event || strobe_event;

    // a shift event carries the strobe level seen with it, so ordering is kept
    always_comb begin
        evt_word = evt_pack(shift_event ? SSX_EVT_SHIFT : SSX_EVT_STROBE, serial_data, latch_load);
    end

    // buffered so a stalled consumer does not lose pin activity until full
    ssx_fifo #(
        .WIDTH(EW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(evt_valid),
        .in_ready(event_ready),
        .in_data(evt_word),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_word)
    );

    assign q_ready = !apply_stall;
    assign apply = q_valid && q_ready;
    assign apply_shift = apply && evt_is_shift(q_word);

    // stage one is bit 0 and takes the queued pin data; every later stage takes its lower neighbour
    for (genvar s = 0; s < STAGES; s++) begin : g_stage
        if (s == 0) begin : g_first
            assign shift_in[s] = evt_data(q_word);
        end else begin : g_rest
            assign shift_in[s] = shift_reg[s-1];
        end
    end

    always_comb begin
        shift_next = shift_reg;
        if (apply_shift) begin
            shift_next = shift_in;
        end
    end

    always_comb begin
        strobe_next = strobe_reg;
        if (apply) begin
            strobe_next = evt_strobe(q_word);
        end
    end

    // clear is not an input here: it only acts on the latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg <= `SSX_SHIFT_RESET;
        end else begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_reg <= `SSX_STROBE_RESET;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    // clear acts immediately, unbuffered; low strobe makes the latch transparent
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_reg <= `SSX_LATCH_RESET;
        end else if (!latch_clear_n) begin
            latch_reg <= `SSX_LATCH_RESET;
        end else if (!strobe_next) begin
            latch_reg <= shift_next;
        end
        // strobe high: latch holds
    end

    // pin activity lost while the buffer is full
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dropped_reg <= 1'b0;
        end else begin
            dropped_reg <= evt_valid && !event_ready;
        end
    end

    assign event_dropped = dropped_reg;
    assign parallel_out = latch_reg;
    assign serial_out = shift_reg[STAGES-1];

endmodule : ssx_expander

// >>> bench/ssx_chk.sv
`timescale 1ns/1ps
module ssx_chk #(
    parameter int STAGES = 8,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host pins
    input wire logic serial_data,
    input wire logic shift_clk,
    input wire logic latch_load,
    input wire logic latch_clear_n,
    input wire logic apply_stall,
    // device pins
    input wire logic [STAGES-1:0] parallel_out,
    input wire logic serial_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic pc_reg, pl_reg;
    logic [7:0] quiet_reg, hi_reg;
    logic sh;
    logic ev;
    assign sh = shift_clk & ~pc_reg;
    assign ev = sh | (latch_load ^ pl_reg);
    // stalls restart both counts, queued events may still land
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_reg <= 1'b1;
            pl_reg <= 1'b1;
            quiet_reg <= 8'h00;
            hi_reg <= 8'h00;
        end else begin
            pc_reg <= shift_clk;
            pl_reg <= latch_load;
            quiet_reg <= (ev | apply_stall) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hFF};
            hi_reg <= (~latch_load | ~latch_clear_n | apply_stall) ? 8'h00 : hi_reg + {7'h00, hi_reg != 8'hFF};
        end
    end
    a_clear_zero: assert property (!latch_clear_n |=> parallel_out == '0)
        else $error("outputs not zero after clear");
    a_clear_held: assert property (!latch_clear_n && $past(!latch_clear_n) |-> parallel_out == '0)
        else $error("outputs rose during clear");
    a_so_quiet: assert property (quiet_reg > 8'd10 |-> $stable(serial_out))
        else $error("serial out moved without shift");
    a_po_quiet: assert property (quiet_reg > 8'd10 && latch_clear_n && $past(latch_clear_n) |-> $stable(parallel_out))
        else $error("outputs moved without event");
    a_hold_high: assert property (hi_reg > 8'd10 |-> $stable(parallel_out))
        else $error("latch changed while strobe high");
    a_shift_follow: assert property ((quiet_reg > 8'd10 && sh && !latch_load && latch_clear_n && $past(latch_clear_n)
        && !apply_stall) ##1 (latch_clear_n && !apply_stall)
        |=> parallel_out == {$past(parallel_out[STAGES-2:0], 2), $past(serial_data, 2)})
        else $error("transparent shift wrong");
    a_so_stage: assert property ((quiet_reg > 8'd10 && sh && !latch_load && latch_clear_n && $past(latch_clear_n)
        && !apply_stall) ##1 !apply_stall |=> serial_out == $past(parallel_out[STAGES-2], 2))
        else $error("serial out not last stage");
    a_clear_keeps: assert property ($rose(latch_clear_n) && quiet_reg > 8'd10 |-> serial_out == $past(serial_out, 3))
        else $error("clear disturbed shift data");
    c_shift: cover property (sh && !latch_load);
    c_load: cover property ($fell(latch_load));
    c_clear: cover property ($rose(latch_clear_n));
endmodule : ssx_chk

bind ssx_expander ssx_chk #(.STAGES(STAGES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk, .rst, .serial_data, .shift_clk,
    .latch_load, .latch_clear_n, .apply_stall, .parallel_out, .serial_out);

// >>> bench/ssx_host.sv
`timescale 1ns/1ps
module ssx_host (
    // clock
    input wire logic clk,
    // host pins
    output logic serial_data,
    output logic shift_clk,
    output logic latch_load,
    output logic latch_clear_n
);
    // clock idles high so no edge leaks while strobe is low
    initial begin
        serial_data = 1'b0;
        shift_clk = 1'b1;
        latch_load = 1'b1;
        latch_clear_n = 1'b1;
    end
    task automatic send_bit(input logic b);
        @(negedge clk);
        serial_data = b;
        shift_clk = 1'b0;
        @(negedge clk);
        shift_clk = 1'b1;
        @(negedge clk);
        // data no longer held after the edge
        serial_data = ~b;
    endtask : send_bit
    task automatic set_pins(input logic load, input logic clr_n);
        @(negedge clk);
        latch_load = load;
        latch_clear_n = clr_n;
    endtask : set_pins
endmodule : ssx_host

// >>> bench/serial_to_parallel_expander_tb.sv
`timescale 1ns/1ps
module serial_to_parallel_expander_tb;
    import ssx_pkg::*;
    logic clk, rst, apply_stall, sd, sc, ld, cn, rdy, drp, so, drp_seen;
    ssx_word_t po, prev, po2;
    int bad_count, checks_done, cyc;
    ssx_word_t rows [5][2] = '{'{8'hA5, 8'h01}, '{8'h3C, 8'h00}, '{8'hFF, 8'h01}, '{8'h00, 8'h00}, '{8'h81, 8'h01}};
    ssx_host host (.clk(clk), .serial_data(sd), .shift_clk(sc), .latch_load(ld), .latch_clear_n(cn));
    ssx_expander DUT (.clk(clk), .rst(rst), .serial_data(sd), .shift_clk(sc), .latch_load(ld), .latch_clear_n(cn),
        .event_ready(rdy), .event_dropped(drp), .apply_stall(apply_stall), .parallel_out(po), .serial_out(so));
    // second stage of a cascade: fed from the cascade output, sharing shift clock, strobe and clear
    ssx_expander DUT_chain (.clk(clk), .rst(rst), .serial_data(so), .shift_clk(sc), .latch_load(ld),
        .latch_clear_n(cn), .event_ready(), .event_dropped(), .apply_stall(apply_stall), .parallel_out(po2),
        .serial_out());
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (drp === 1'b1) drp_seen = 1'b1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk(input string n, input ssx_word_t seen, input ssx_word_t exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    initial begin
        rst = 1'b1;
        apply_stall = 1'b0;
        drp_seen = 1'b0;
        prev = 8'h00;
        w(12);
        rst = 1'b0;
        chk("reset out", {so, po[6:0]}, 8'h00);
        foreach (rows[i]) begin
            for (int b = 7; b >= 0; b--) host.send_bit(rows[i][0][b]);
            w(3);
            chk("hold", po, prev);
            chk("cascade", {7'h00, so}, rows[i][1]);
            host.set_pins(1'b0, 1'b1);
            w(3);
            chk("load", po, rows[i][0]);
            chk("chain", po2, prev);
            host.set_pins(1'b1, 1'b1);
            prev = rows[i][0];
        end
        host.set_pins(1'b0, 1'b1);
        // let the strobe event settle so the transparent-shift checks can engage
        w(12);
        host.send_bit(1'b0);
        w(3);
        chk("follow", po, 8'h02);
        host.set_pins(1'b0, 1'b0);
        w(2);
        chk("clear", po, 8'h00);
        // strobe goes high before clear lifts, else the transparent latch refills at release
        host.set_pins(1'b1, 1'b0);
        w(12);
        host.set_pins(1'b1, 1'b1);
        host.send_bit(1'b1);
        w(3);
        chk("clear hold", po, 8'h00);
        host.set_pins(1'b0, 1'b1);
        w(3);
        chk("kept", po, 8'h05);
        apply_stall = 1'b1;
        for (int k = 0; k < 10; k++) host.set_pins(k[0], 1'b1);
        w(2);
        chk("full", {7'h00, rdy}, 8'h00);
        chk("dropped", {7'h00, drp_seen}, 8'h01);
        apply_stall = 1'b0;
        w(12);
        chk("drained", {7'h00, rdy}, 8'h01);
        rst = 1'b1;
        w(2);
        chk("reset again", {so, po[6:0]}, 8'h00);
        print_verdict();
    end
endmodule : serial_to_parallel_expander_tb
